// File: verilog/trr_recorder.sv
// sweep capture, ring buffer, time base and host transfer for one channel
`timescale 1ns/100ps
module trr_recorder #(
    parameter int SEG_W = 2,
    parameter int OFF_W = 8,
    parameter int DW    = 16
) (
    input  wire logic          ref_clk_i,
    input  wire logic          rst_i,
    input  wire logic          psel_i,
    input  wire logic          penable_i,
    input  wire logic          pwrite_i,
    input  wire logic [7:0]    paddr_i,
    input  wire logic [31:0]   pwdata_i,
    output logic      [31:0]   prdata_o,
    output logic               pready_o,
    output logic               pslverr_o,
    input  wire logic          clk_base_bin_i,
    input  wire logic          ext_clk_i,
    output logic               adc_start_o,
    input  wire logic          adc_valid_i,
    input  wire logic [DW-1:0] adc_data_i,
    input  wire logic          trig_i,
    output logic      [DW-1:0] host_data_o,
    output logic               host_valid_o,
    input  wire logic          host_ready_i
);
    localparam int AW   = SEG_W + OFF_W;
    localparam int NSEG = 2 ** SEG_W;

    logic [DW-1:0]        mem [0:(2**AW)-1];
    logic [OFF_W-1:0]     trig_adr [0:NSEG-1];
    trr_pkg::trr_state_t  st_reg, st_next;
    logic [2:0]           mode_reg;
    logic                 ext_sel_reg, pause_reg, ovf_reg, ext_d_reg;
    logic [15:0]          div_reg, delay_reg, div_cnt_reg;
    logic [31:0]          time_reg, tcnt_reg, nco_reg;
    logic [15:0]          dcnt_reg;
    logic [SEG_W-1:0]     seg_reg;
    logic [OFF_W-1:0]     off_reg;
    logic [OFF_W:0]       drain_reg;
    logic [AW-1:0]        rd_adr_reg;
    logic [NSEG-1:0]      done_reg;

    // apb decode; one wait-free access phase after every setup
    wire setup  = psel_i & ~penable_i;
    wire access = psel_i & penable_i & pready_o;
    wire wr     = access & pwrite_i;
    wire rd     = access & ~pwrite_i;
    wire hit    = paddr_i <= trr_pkg::OFF_RDDATA && paddr_i[1:0] == 2'b00;
    wire [31:0] cmd = (wr && paddr_i == trr_pkg::OFF_CMD) ? pwdata_i : 32'h0000_0000;
    wire c_rec   = cmd[trr_pkg::CMD_RECORD];
    wire c_stop  = cmd[trr_pkg::CMD_STOP];
    wire ovf_clr = wr && paddr_i == trr_pkg::OFF_STATUS && pwdata_i[trr_pkg::ST_OVF_BIT];

    // time base: phase accumulator main oscillator, divisor, source select
    wire [31:0] nco_step = clk_base_bin_i ? trr_pkg::BIN_STEP : trr_pkg::DEC_STEP;
    wire [32:0] nco_sum  = {1'b0, nco_reg} + {1'b0, nco_step};
    wire        main_tick = nco_sum[32];
    wire [16:0] div_inc  = {1'b0, div_cnt_reg} + 17'h0_0001;
    wire        div_wrap = div_inc >= {1'b0, div_reg};
    wire        ext_rise = ext_clk_i & ~ext_d_reg;
    wire        conv = ext_sel_reg ? ext_rise : (main_tick & div_wrap);

    // sample and trigger qualification
    wire smp  = adc_valid_i & ~pause_reg;
    wire trig = trig_i | cmd[trr_pkg::CMD_TRIG];
    wire slot_free = ~host_valid_o | host_ready_i;
    wire sweep_wr  = (st_reg == trr_pkg::S_FILL || st_reg == trr_pkg::S_POST) & smp;
    wire cont_push = (st_reg == trr_pkg::S_CONT || st_reg == trr_pkg::S_LEAD) & smp;
    wire [OFF_W-1:0] drain_off = off_reg + drain_reg[OFF_W-1:0];
    wire drain_push = (st_reg == trr_pkg::S_DRAIN) & slot_free & ~c_stop;
    wire drain_last = drain_push & (drain_reg == (OFF_W+1)'(2**OFF_W - 1));
    wire dly_end    = smp & (dcnt_reg == 16'h0001) & ~trig;

    // register readback, captured at setup so it is stable in access
    wire [SEG_W-1:0] rd_seg = rd_adr_reg[AW-1:OFF_W];
    wire [DW-1:0] rd_word = done_reg[rd_seg] ? mem[rd_adr_reg] : '0;
    wire [31:0] status = {{(16-NSEG){1'b0}}, done_reg, {(8-SEG_W){1'b0}}, seg_reg,
                          3'b000, ovf_reg, pause_reg, st_reg};
    wire [31:0] rd_mux =
        paddr_i == trr_pkg::OFF_CTRL    ? {28'h0, ext_sel_reg, mode_reg} :
        paddr_i == trr_pkg::OFF_DIV     ? {16'h0, div_reg} :
        paddr_i == trr_pkg::OFF_DELAY   ? {16'h0, delay_reg} :
        paddr_i == trr_pkg::OFF_TIME    ? time_reg :
        paddr_i == trr_pkg::OFF_STATUS  ? status :
        paddr_i == trr_pkg::OFF_TRIGADR ? {{(32-OFF_W){1'b0}}, trig_adr[rd_seg]} :
        paddr_i == trr_pkg::OFF_RDADR   ? {{(32-AW){1'b0}}, rd_adr_reg} :
        paddr_i == trr_pkg::OFF_RDDATA  ? {{(32-DW){1'b0}}, rd_word} : 32'h0000_0000;

    // apb answer flops
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            pready_o  <= 1'b0;
            pslverr_o <= 1'b0;
            prdata_o  <= 32'h0000_0000;
        end else begin
            pready_o  <= setup;
            pslverr_o <= setup & ~hit;
            if (setup) begin
                prdata_o <= rd_mux;
            end
        end
    end

    // software configuration registers
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            mode_reg    <= trr_pkg::MODE_SWEEP;
            ext_sel_reg <= 1'b0;
            div_reg     <= trr_pkg::DIV_RST;
            delay_reg   <= trr_pkg::DELAY_RST;
            time_reg    <= trr_pkg::TIME_RST;
        end else if (wr) begin
            if (paddr_i == trr_pkg::OFF_CTRL) begin
                mode_reg    <= pwdata_i[trr_pkg::CTRL_MODE_LSB +: 3];
                ext_sel_reg <= pwdata_i[trr_pkg::CTRL_EXT_BIT];
            end
            if (paddr_i == trr_pkg::OFF_DIV) begin
                div_reg <= pwdata_i[15:0];
            end
            if (paddr_i == trr_pkg::OFF_DELAY) begin
                delay_reg <= pwdata_i[15:0];
            end
            if (paddr_i == trr_pkg::OFF_TIME) begin
                time_reg <= pwdata_i;
            end
        end
    end

    // host read pointer, post-increments on each data read
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            rd_adr_reg <= '0;
        end else if (wr && paddr_i == trr_pkg::OFF_RDADR) begin
            rd_adr_reg <= pwdata_i[AW-1:0];
        end else if (rd && paddr_i == trr_pkg::OFF_RDDATA) begin
            rd_adr_reg <= rd_adr_reg + 1'b1;
        end
    end

    // time base counters and conversion pulse out
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            nco_reg     <= 32'h0000_0000;
            div_cnt_reg <= 16'h0000;
            ext_d_reg   <= 1'b0;
            adc_start_o <= 1'b0;
        end else begin
            nco_reg   <= nco_sum[31:0];
            ext_d_reg <= ext_clk_i;
            if (main_tick) begin
                div_cnt_reg <= div_wrap ? 16'h0000 : div_inc[15:0];
            end
            adc_start_o <= conv;
        end
    end

    // next state; ring filling ends at trigger delay expiry, at the trigger itself when the delay is zero, or on stop
    always_comb begin
        st_next = st_reg;
        case (st_reg)
            trr_pkg::S_IDLE: begin
                if (c_rec) begin
                    st_next = (mode_reg == trr_pkg::MODE_SWEEP) ? trr_pkg::S_FILL
                                                                : trr_pkg::S_CONT;
                end
            end
            trr_pkg::S_FILL: begin
                if (trig) begin
                    st_next = (delay_reg == 16'h0000) ? trr_pkg::S_DRAIN : trr_pkg::S_POST;
                end
            end
            trr_pkg::S_POST: begin
                if (dly_end) begin
                    st_next = trr_pkg::S_DRAIN;
                end
            end
            trr_pkg::S_DRAIN: begin
                if (drain_last) begin
                    st_next = trr_pkg::S_FILL; // next sweep, next segment
                end
            end
            trr_pkg::S_CONT: begin
                if (trig && mode_reg == trr_pkg::MODE_CIRCULAR) begin
                    st_next = trr_pkg::S_LEAD;
                end else if (trig && mode_reg == trr_pkg::MODE_STOPTRIG) begin
                    st_next = trr_pkg::S_IDLE;
                end else if (mode_reg == trr_pkg::MODE_TIMED && adc_valid_i
                             && tcnt_reg <= 32'h0000_0001) begin
                    st_next = trr_pkg::S_IDLE;
                end
            end
            trr_pkg::S_LEAD: begin
                if (dly_end) begin
                    st_next = trr_pkg::S_IDLE;
                end
            end
            default: st_next = trr_pkg::S_IDLE;
        endcase
        if (c_stop) begin
            st_next = trr_pkg::S_IDLE;
        end
    end

    // state, pause and delay counting
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            st_reg    <= trr_pkg::S_IDLE;
            pause_reg <= 1'b0;
            dcnt_reg  <= 16'h0000;
            tcnt_reg  <= 32'h0000_0000;
        end else begin
            st_reg <= st_next;
            if (cmd[trr_pkg::CMD_PAUSE]) begin
                pause_reg <= 1'b1;
            end else if (cmd[trr_pkg::CMD_RESUME] || c_stop) begin
                pause_reg <= 1'b0;
            end
            if (trig) begin
                dcnt_reg <= delay_reg;
            end else if (smp && dcnt_reg != 16'h0000) begin
                dcnt_reg <= dcnt_reg - 16'h0001;
            end
            if (c_rec) begin
                tcnt_reg <= time_reg;
            end else if (adc_valid_i && tcnt_reg != 32'h0000_0000) begin
                tcnt_reg <= tcnt_reg - 32'h0000_0001; // time runs through pause
            end
        end
    end

    // ring write; offset width wraps inside the segment
    always_ff @(posedge ref_clk_i) begin
        if (sweep_wr) begin
            mem[{seg_reg, off_reg}] <= adc_data_i;
        end
    end

    // segment bookkeeping and drain counter
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            seg_reg   <= '0;
            off_reg   <= '0;
            drain_reg <= '0;
            done_reg  <= '0;
        end else begin
            if (st_reg == trr_pkg::S_IDLE && c_rec) begin
                seg_reg <= '0;
                off_reg <= '0;
            end else if (sweep_wr) begin
                off_reg <= off_reg + 1'b1;
            end
            if (st_reg == trr_pkg::S_FILL && st_next == trr_pkg::S_FILL) begin
                done_reg[seg_reg] <= 1'b0; // segment being overwritten
            end
            if (st_reg != trr_pkg::S_DRAIN) begin
                drain_reg <= '0;
            end else if (drain_last) begin
                done_reg[seg_reg] <= 1'b1;
                seg_reg <= seg_reg + 1'b1;
                off_reg <= '0;
            end else if (drain_push) begin
                drain_reg <= drain_reg + 1'b1;
            end
        end
    end

    // trigger address per segment for later reordering
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            for (int i = 0; i < NSEG; i++) begin
                trig_adr[i] <= '0;
            end
        end else if (trig && st_reg == trr_pkg::S_FILL) begin
            trig_adr[seg_reg] <= off_reg;
        end
    end

    // host stream: drained sweeps oldest first, or live continuous samples
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            host_valid_o <= 1'b0;
            host_data_o  <= '0;
            ovf_reg      <= 1'b0;
        end else begin
            if (drain_push) begin
                host_valid_o <= 1'b1;
                host_data_o  <= mem[{seg_reg, drain_off}];
            end else if (cont_push && slot_free) begin
                host_valid_o <= 1'b1;
                host_data_o  <= adc_data_i;
            end else if (host_ready_i) begin
                host_valid_o <= 1'b0;
            end
            // overrun set wins over software clear
            ovf_reg <= (cont_push & ~slot_free) | (ovf_reg & ~ovf_clr);
        end
    end
endmodule : trr_recorder

// File: verilog/trr_pkg.sv
// shared constants for the triggered sweep ring recorder
package trr_pkg;
    // apb register byte offsets
    localparam logic [7:0] OFF_CTRL    = 8'h00;
    localparam logic [7:0] OFF_CMD     = 8'h04;
    localparam logic [7:0] OFF_DIV     = 8'h08;
    localparam logic [7:0] OFF_DELAY   = 8'h0C;
    localparam logic [7:0] OFF_TIME    = 8'h10;
    localparam logic [7:0] OFF_STATUS  = 8'h14;
    localparam logic [7:0] OFF_TRIGADR = 8'h18;
    localparam logic [7:0] OFF_RDADR   = 8'h1C;
    localparam logic [7:0] OFF_RDDATA  = 8'h20;
    // ctrl fields
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_EXT_BIT  = 3;
    // command bits, write one to act
    localparam int CMD_RECORD = 0;
    localparam int CMD_STOP   = 1;
    localparam int CMD_PAUSE  = 2;
    localparam int CMD_RESUME = 3;
    localparam int CMD_TRIG   = 4;
    // status fields
    localparam int ST_STATE_LSB = 0;
    localparam int ST_PAUSE_BIT = 3;
    localparam int ST_OVF_BIT   = 4;
    localparam int ST_SEG_LSB   = 8;
    localparam int ST_DONE_LSB  = 16;
    // reset values
    localparam logic [15:0] DIV_RST   = 16'h0001;
    localparam logic [15:0] DELAY_RST = 16'h0000;
    localparam logic [31:0] TIME_RST  = 32'h0000_0000;
    // time base: main oscillators built by phase accumulator from ref clock
    localparam longint REF_HZ      = 125000000;
    localparam longint DEC_MAIN_HZ = 1000000;
    localparam longint BIN_MAIN_HZ = 1024000;
    localparam logic [31:0] DEC_STEP = 32'((DEC_MAIN_HZ << 32) / REF_HZ);
    localparam logic [31:0] BIN_STEP = 32'((BIN_MAIN_HZ << 32) / REF_HZ);
    // storage modes
    typedef enum logic [2:0] {
        MODE_SWEEP    = 3'b000,
        MODE_STANDARD = 3'b001,
        MODE_CIRCULAR = 3'b010,
        MODE_STOPTRIG = 3'b011,
        MODE_TIMED    = 3'b100
    } trr_mode_t;
    // recorder states
    typedef enum logic [2:0] {
        S_IDLE  = 3'b000,
        S_FILL  = 3'b001,
        S_POST  = 3'b010,
        S_DRAIN = 3'b011,
        S_CONT  = 3'b100,
        S_LEAD  = 3'b101
    } trr_state_t;
endpackage : trr_pkg

// File: dv/trr_recorder_props.sv
// port checker for the sweep ring recorder
`timescale 1ns/100ps
module trr_recorder_props #(
    parameter int DW = 16
) (
    input wire logic          ref_clk_i,
    input wire logic          rst_i,
    input wire logic          psel_i,
    input wire logic          penable_i,
    input wire logic [7:0]    paddr_i,
    input wire logic [31:0]   prdata_o,
    input wire logic          pready_o,
    input wire logic          pslverr_o,
    input wire logic          adc_start_o,
    input wire logic [DW-1:0] host_data_o,
    input wire logic          host_valid_o,
    input wire logic          host_ready_i
);
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);
    // apb setup phase, and a host word left waiting
    sequence s_setup; psel_i && !penable_i; endsequence
    sequence s_stall; host_valid_o && !host_ready_i; endsequence
    a_ready_after_setup: assert property (s_setup |=> pready_o)
        else $error("no ready after setup");
    a_ready_one_cycle: assert property (pready_o |=> !pready_o)
        else $error("ready longer than one cycle");
    a_err_with_ready: assert property (pslverr_o |-> pready_o)
        else $error("error without ready");
    a_unmapped_err: assert property (
        s_setup ##0 (paddr_i[1:0] != 2'h0 || paddr_i > 8'h20) |=> pslverr_o)
        else $error("unmapped access not refused");
    a_refused_zero: assert property (pslverr_o |-> prdata_o == 32'h0000_0000)
        else $error("refused read not zero");
    a_start_pulse: assert property (adc_start_o |=> !adc_start_o)
        else $error("conversion request wider than one cycle");
    // a word the host has not taken must stay put, or sweep data is lost
    a_host_hold: assert property (s_stall |=> host_valid_o && $stable(host_data_o))
        else $error("host word dropped or changed");
    a_quiet_reset: assert property (
        $fell(rst_i) |-> !host_valid_o && !adc_start_o && !pready_o)
        else $error("outputs busy out of reset");
endmodule : trr_recorder_props

bind trr_recorder trr_recorder_props #(.DW(DW)) i_trr_recorder_props (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .psel_i(psel_i), .penable_i(penable_i),
    .paddr_i(paddr_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .adc_start_o(adc_start_o), .host_data_o(host_data_o), .host_valid_o(host_valid_o),
    .host_ready_i(host_ready_i));

// File: dv/trr_far_model.sv
// far side: converter, external sample clock and host sink
`timescale 1ns/100ps
module trr_far_model (
    input  wire logic   clk_i,
    input  wire logic   rst_i,
    input  wire logic   stall_i,
    input  wire logic   adc_start_i,
    output logic        ext_clk_o,
    output logic        adc_valid_o,
    output logic [15:0] adc_data_o,
    output logic        host_ready_o
);
    logic [1:0]  div_reg;
    logic [15:0] count_reg;
    // every request converts, so the sample index runs on while the recorder pauses
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            div_reg      <= 2'h0;
            ext_clk_o    <= 1'b0;
            count_reg    <= 16'h0000;
            adc_valid_o  <= 1'b0;
            adc_data_o   <= 16'h0000;
            host_ready_o <= 1'b0;
        end else begin
            div_reg      <= div_reg + 2'h1;
            ext_clk_o    <= div_reg[1];
            adc_valid_o  <= adc_start_i;
            count_reg    <= count_reg + {15'h0000, adc_start_i};
            adc_data_o   <= adc_start_i ? count_reg : ~adc_data_o; // idle lines scramble
            host_ready_o <= ~stall_i;
        end
    end
endmodule : trr_far_model

// File: dv/tb_top.sv
// self-checking bench for the sweep ring recorder
`timescale 1ns/100ps
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin miscompares++; \
    $display("unexpected t=%0t got %0h exp %0h", $time, (a), (e)); end end
module tb_top;
    logic        clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic        bin_sel = 1'b0, trig = 1'b0, stall = 1'b0, pready, pslverr;
    logic        ext_clk, adc_start, adc_valid, host_valid, host_ready, err;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
    logic [15:0] adc_data, host_data, v;
    logic [15:0] hq[$];
    int          miscompares, num_checks, p, n;
    int          lo[3] = '{99, 101, 3124};
    int          ex[3] = '{13, 10, 5};
    trr_recorder i_trr_recorder (.ref_clk_i(clk), .rst_i(rst), .psel_i(psel),
        .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
        .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .clk_base_bin_i(bin_sel),
        .ext_clk_i(ext_clk), .adc_start_o(adc_start), .adc_valid_i(adc_valid),
        .adc_data_i(adc_data), .trig_i(trig), .host_data_o(host_data),
        .host_valid_o(host_valid), .host_ready_i(host_ready));
    trr_far_model i_trr_far_model (.clk_i(clk), .rst_i(rst), .stall_i(stall),
        .adc_start_i(adc_start), .ext_clk_o(ext_clk), .adc_valid_o(adc_valid),
        .adc_data_o(adc_data), .host_ready_o(host_ready));
    initial forever #4 clk = ~clk;
    // the host keeps every word it accepts
    always @(posedge clk)
        if (host_valid === 1'b1 && host_ready === 1'b1) hq.push_back(host_data);
    // one apb transfer; waits for ready, never assumes its latency
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge clk);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        for (k = 0; k < 16 && pready !== 1'b1; k++) @(posedge clk);
        if (k == 16) miscompares++;
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic cmd(input logic [31:0] d);
        apb(1'b1, trr_pkg::OFF_CMD, d);
    endtask : cmd
    task automatic chk(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0000_0000);
        `CHK(rd, e)
    endtask : chk
    task automatic wait_s(input int k);
        repeat (k) @(posedge clk iff adc_valid === 1'b1);
    endtask : wait_s
    // one sweep: wrap the ring, trigger, maybe stretch, then check the drained segment
    task automatic sweep(input logic [1:0] s, input int gap, input int ep, input logic [31:0] st);
        int bad;
        bad = 0;
        wait_s(300);
        trig <= 1'b1;
        @(posedge clk);
        trig <= 1'b0;
        if (gap > 0) begin
            wait_s(gap);
            cmd(32'h0000_0010);
        end
        while (hq.size() < 16) @(posedge clk);
        stall <= 1'b1;
        repeat (12) @(posedge clk);
        stall <= 1'b0;
        while (hq.size() < 256) @(posedge clk);
        for (int i = 1; i < 256; i++) if (hq[i] !== hq[i-1] + 16'h0001) bad++;
        `CHK(bad, 0)
        chk(trr_pkg::OFF_STATUS, st);
        apb(1'b1, trr_pkg::OFF_RDADR, {22'h0, s, 8'h00});
        apb(1'b0, trr_pkg::OFF_TRIGADR, 32'h0000_0000);
        apb(1'b1, trr_pkg::OFF_RDADR, {22'h0, s, rd[7:0]});
        apb(1'b0, trr_pkg::OFF_RDDATA, 32'h0000_0000);
        v = rd[15:0];
        chk(trr_pkg::OFF_RDDATA, {16'h0000, v + 16'h0001});
        p = -1;
        foreach (hq[i]) if (hq[i] === v) p = i;
        `CHK(p, ep)
        hq.delete();
    endtask : sweep
    initial begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        chk(trr_pkg::OFF_DIV, 32'h0000_0001);
        chk(trr_pkg::OFF_DELAY, 32'h0000_0000);
        chk(trr_pkg::OFF_TIME, 32'h0000_0000);
        chk(trr_pkg::OFF_CMD, 32'h0000_0000);
        chk(8'h24, 32'h0000_0000);
        `CHK(err, 1'b1)
        // decimal, binary, then external time base
        for (int b = 0; b < 3; b++) begin
            n = 0;
            bin_sel <= (b == 1);
            apb(1'b1, trr_pkg::OFF_CTRL, (b == 2) ? 32'h0000_0008 : 32'h0000_0000);
            repeat (12500) @(posedge clk) if (adc_start === 1'b1) n++;
            `CHK(n inside {[lo[b]:lo[b]+2]}, 1'b1)
        end
        // divided decimal base, then back to the external clock for quick sweeps
        apb(1'b1, trr_pkg::OFF_DIV, 32'h0000_0005);
        apb(1'b1, trr_pkg::OFF_CTRL, 32'h0000_0000);
        n = 0;
        repeat (12500) @(posedge clk) if (adc_start === 1'b1) n++;
        `CHK(n inside {[19:21]}, 1'b1)
        apb(1'b1, trr_pkg::OFF_CTRL, 32'h0000_0008);
        apb(1'b1, trr_pkg::OFF_DELAY, 32'h0000_0064);
        cmd(32'h0000_0001);
        sweep(2'h0, 0, 156, 32'h0001_0101);
        sweep(2'h1, 50, 106, 32'h0003_0201);
        // delay of a whole segment: the trigger sample is the oldest word kept
        apb(1'b1, trr_pkg::OFF_DELAY, 32'h0000_0100);
        sweep(2'h2, 0, 0, 32'h0007_0301);
        cmd(32'h0000_0002);
        apb(1'b0, trr_pkg::OFF_STATUS, 32'h0000_0000);
        `CHK(rd[2:0], 3'h0)
        // standard continuous with a pause in the middle
        apb(1'b1, trr_pkg::OFF_CTRL, 32'h0000_0009);
        cmd(32'h0000_0001);
        wait_s(10);
        cmd(32'h0000_0004);
        repeat (3) @(posedge clk);
        hq.delete();
        wait_s(20);
        `CHK(hq.size(), 0)
        cmd(32'h0000_0008);
        wait_s(20);
        `CHK(hq.size() inside {[19:21]}, 1'b1)
        // a host stalled across three samples loses two and the overrun bit sticks
        stall <= 1'b1;
        wait_s(3);
        stall <= 1'b0;
        apb(1'b0, trr_pkg::OFF_STATUS, 32'h0000_0000);
        `CHK(rd[4], 1'b1)
        apb(1'b1, trr_pkg::OFF_STATUS, 32'h0000_0010);
        apb(1'b0, trr_pkg::OFF_STATUS, 32'h0000_0000);
        `CHK(rd[4], 1'b0)
        cmd(32'h0000_0002);
        apb(1'b1, trr_pkg::OFF_DELAY, 32'h0000_0003);
        apb(1'b1, trr_pkg::OFF_TIME, 32'h0000_0005);
        // circular, stop on trigger and timed: words sent from record to the end
        for (int m = 2; m < 5; m++) begin
            repeat (8) @(posedge clk);
            hq.delete();
            apb(1'b1, trr_pkg::OFF_CTRL, 32'h0000_0008 | m);
            cmd(32'h0000_0001);
            wait_s(10);
            cmd(32'h0000_0010);
            wait_s(10);
            `CHK(hq.size(), ex[m-2])
        end
        final_report();
    end
    // a hang is cut short well after the tests should have ended
    initial begin
        repeat (80000) @(posedge clk);
        miscompares++;
        final_report();
    end
    task automatic final_report();
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : final_report
endmodule : tb_top
